// ===== include/rpxb_pkg.sv
// Functional notes
// - Two independent row pointers: one for readout, one for reset.
// - A row is reset again right after readout for double sampling.
// - Sampled reset level minus sampled signal cancels fixed pattern noise.
// - Pointers reach 4536 x 3024 active pixels plus 24 extra columns and rows.
// - Row and column pointers support subsampling modes chosen by configuration.
// - Each output amplifier is enabled or powered down individually by configuration.
// - Pixel 0,0 is green on a green-red row; colours map from there.
// - Crossbar routes green pixels always to the same output.
// - Crossbar is automatic (toggle per row clock) or manual from configuration.
// - In automatic mode, crossbar sync resets crossbar to its configured initial state.
// - With automatic mode, crossbar flips on every rising crossbar row clock that comes without crossbar sync.
// - Each rising pointer clock advances that pointer to the next row.
// - Sync sampled on rising pointer clock returns pointer to the first row.
package rpxb_pkg;
  localparam int ROW_W = 12;
  localparam int COL_W = 13;
  localparam int EXTRA_LINES = 24;
  localparam logic [ROW_W-1:0] ACTIVE_ROWS = 12'hBD0;
  localparam logic [COL_W-1:0] ACTIVE_COLS = 13'h11B8;
  localparam logic [ROW_W-1:0] LAST_ROW = 12'hBE7;
  localparam logic [COL_W-1:0] LAST_COL = 13'h11CF;
  localparam logic [4:0] ROW_STEP = 5'h01;
  localparam logic [4:0] COL_STEP = 5'h04;
  localparam logic [1:0] ROW_GROUP = 2'h2;
  localparam logic [1:0] COL_GROUP = 2'h1;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ROWS = 8'h08;
  localparam logic [7:0] OFF_COL = 8'h0C;
  localparam logic [7:0] OFF_CDS = 8'h10;
  // Control fields
  localparam int F_XB_AUTO = 0;
  localparam int F_XB_INIT = 1;
  localparam int F_XB_MAN = 2;
  localparam int F_XSUB = 4;
  localparam int F_YSUB = 8;
  localparam int F_AMP = 12;
  localparam int ROWS_RST_POS = 16;
  localparam logic [15:0] CTRL_RESET = 16'hF101;
  localparam logic [15:0] CTRL_MASK = 16'hF777;
  // Subsample mode codes
  localparam logic [2:0] YS_FULL = 3'h1;
  localparam logic [2:0] YS_SKIP4 = 3'h3;
  localparam logic [2:0] YS_SKIP10 = 3'h5;
  localparam logic [2:0] XS_SKIP20 = 3'h3;
  localparam logic [2:0] XS_SKIP4 = 3'h4;
  localparam logic [2:0] XS_SKIP8 = 3'h5;
  typedef enum logic [1:0] {
    CLR_GREEN = 2'h0,
    CLR_RED = 2'h1,
    CLR_BLUE = 2'h2
  } rpxb_colour_type;
endpackage

// ===== rtl/rpxb_row_pointer.sv
`timescale 1ns/1ns
module rpxb_row_pointer
  import rpxb_pkg::*;
#(
  parameter int PTR_W = 12,
  parameter logic [PTR_W-1:0] ACTIVE = '0,
  parameter logic [PTR_W-1:0] LAST = '1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sysRst,
  input wire logic clkEn,
  // Pointer control
  input wire logic advance,
  input wire logic restart,
  input wire logic [4:0] unitStep,
  input wire logic [1:0] groupLen,
  input wire logic [4:0] skipUnits,
  // Position
  output logic [PTR_W-1:0] ptr_q
);
  logic [PTR_W-1:0] ptr_d;
  logic [1:0] grp_q;
  logic [1:0] grp_d;
  logic [PTR_W:0] sum;

  always_comb begin
    ptr_d = ptr_q;
    grp_d = grp_q;
    sum = {1'b0, ptr_q} + {{(PTR_W-4){1'b0}}, unitStep};
    if (advance) begin
      if (restart) begin
        ptr_d = '0;
        grp_d = 2'h0;
      end else begin
        // Extra lines beyond the active area never skip
        if (ptr_q < ACTIVE && grp_q == groupLen - 2'h1) begin
          sum = sum + {{(PTR_W-4){1'b0}}, skipUnits};
          grp_d = 2'h0;
        end else if (ptr_q < ACTIVE) begin
          grp_d = grp_q + 2'h1;
        end
        // Wrap keeps the pointer inside the addressable array
        ptr_d = (sum > {1'b0, LAST}) ? '0 : sum[PTR_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sysRst) begin
      ptr_q <= '0;
      grp_q <= 2'h0;
    end else if (clkEn) begin
      ptr_q <= ptr_d;
      grp_q <= grp_d;
    end
  end
endmodule

// ===== rtl/rpxb_top.sv
`timescale 1ns/1ns
module rpxb_top
  import rpxb_pkg::*;
#(
  parameter int PIX_W = 12
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sysRst,
  input wire logic clkEn,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // Sensor timing pins from the camera controller
  input wire logic readoutRowClock,
  input wire logic readoutRowSync,
  input wire logic resetRowClock,
  input wire logic resetRowSync,
  input wire logic xbarRowClock,
  input wire logic xbarSync,
  input wire logic colClock,
  input wire logic colSync,
  input wire logic signalSampleHold,
  input wire logic resetLevelSampleHold,
  // Column level, already in this clock domain
  input wire logic [PIX_W-1:0] pixelLevel,
  // Row and column selection
  output logic [ROW_W-1:0] readRowAddr,
  output logic [ROW_W-1:0] resetRowAddr,
  output logic [COL_W-1:0] colAddr,
  output logic rowResetStrobe,
  output logic [ROW_W-1:0] rowResetAddr,
  // Corrected level
  output logic [PIX_W-1:0] correctedLevel,
  output logic correctedValid,
  // Output stage
  output logic xbarSwap,
  output logic [3:0] ampEnable,
  output logic [1:0] pixelColour
);
  localparam int NPIN = 10;

  // Pin synchronisers: meta feeds only stable
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] stable_q;
  logic [NPIN-1:0] prev_q;
  logic [NPIN-1:0] rise;
  assign pinRaw = {resetLevelSampleHold, signalSampleHold, colSync, colClock, xbarSync, xbarRowClock,
                   resetRowSync, resetRowClock, readoutRowSync, readoutRowClock};
  assign rise = stable_q & ~prev_q;

  always_ff @(posedge clk) begin
    if (sysRst) begin
      meta_q <= '0;
      stable_q <= '0;
      prev_q <= '0;
    end else if (clkEn) begin
      meta_q <= pinRaw;
      stable_q <= meta_q;
      prev_q <= stable_q;
    end
  end

  logic readRise;
  logic resetRise;
  logic xbarRise;
  logic colRise;
  logic sigHoldRise;
  logic rstHoldRise;
  assign readRise = rise[0];
  assign resetRise = rise[2];
  assign xbarRise = rise[4];
  assign colRise = rise[6];
  assign sigHoldRise = rise[8];
  assign rstHoldRise = rise[9];

  // Control register
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [31:0] datR_q;
  logic [31:0] datR_d;
  logic ack_q;
  logic ack_d;
  logic xbarAuto;
  logic [2:0] xSub;
  logic [2:0] ySub;
  assign xbarAuto = ctrl_q[F_XB_AUTO];
  assign xSub = ctrl_q[F_XSUB +: 3];
  assign ySub = ctrl_q[F_YSUB +: 3];

  // Row skip per Y mode: rows go in pairs; every mode but YS_FULL, 6 and 7 skips after each pair
  function automatic logic [4:0] ySkip(input logic [2:0] mode);
    case (mode)
      YS_FULL: ySkip = 5'h00;
      YS_SKIP4: ySkip = 5'h04;
      YS_SKIP10: ySkip = 5'h0A;
      3'h0, 3'h2, 3'h4: ySkip = 5'h02;
      default: ySkip = 5'h00;
    endcase
  endfunction

  // Column skip per X mode, after each group of four columns
  function automatic logic [4:0] xSkip(input logic [2:0] mode);
    case (mode)
      XS_SKIP20: xSkip = 5'h14;
      XS_SKIP4: xSkip = 5'h04;
      XS_SKIP8: xSkip = 5'h08;
      default: xSkip = 5'h00;
    endcase
  endfunction

  function automatic logic [1:0] colourAt(input logic rowOdd, input logic colOdd);
    if (!rowOdd) begin
      colourAt = colOdd ? CLR_RED : CLR_GREEN;
    end else begin
      colourAt = colOdd ? CLR_GREEN : CLR_BLUE;
    end
  endfunction

  // Pointers: readout, reset and column are fully independent
  logic [ROW_W-1:0] readPtr;
  logic [ROW_W-1:0] resetPtr;
  logic [COL_W-1:0] colPtr;

  rpxb_row_pointer #(.PTR_W(ROW_W), .ACTIVE(ACTIVE_ROWS), .LAST(LAST_ROW)) uReadPtr (
    .clk(clk),
    .sysRst(sysRst),
    .clkEn(clkEn),
    .advance(readRise),
    .restart(stable_q[1]),
    .unitStep(ROW_STEP),
    .groupLen(ROW_GROUP),
    .skipUnits(ySkip(ySub)),
    .ptr_q(readPtr)
  );

  rpxb_row_pointer #(.PTR_W(ROW_W), .ACTIVE(ACTIVE_ROWS), .LAST(LAST_ROW)) uResetPtr (
    .clk(clk),
    .sysRst(sysRst),
    .clkEn(clkEn),
    .advance(resetRise),
    .restart(stable_q[3]),
    .unitStep(ROW_STEP),
    .groupLen(ROW_GROUP),
    .skipUnits(ySkip(ySub)),
    .ptr_q(resetPtr)
  );

  rpxb_row_pointer #(.PTR_W(COL_W), .ACTIVE(ACTIVE_COLS), .LAST(LAST_COL)) uColPtr (
    .clk(clk),
    .sysRst(sysRst),
    .clkEn(clkEn),
    .advance(colRise),
    .restart(stable_q[7]),
    .unitStep(COL_STEP),
    .groupLen(COL_GROUP),
    .skipUnits(xSkip(xSub)),
    .ptr_q(colPtr)
  );

  assign readRowAddr = readPtr;
  assign resetRowAddr = resetPtr;
  assign colAddr = colPtr;

  // Crossbar, double sampling and row reset state
  logic xbar_q;
  logic xbar_d;
  logic [PIX_W-1:0] sig_q;
  logic [PIX_W-1:0] sig_d;
  logic [PIX_W-1:0] cds_q;
  logic [PIX_W-1:0] cds_d;
  logic cdsValid_q;
  logic cdsValid_d;
  logic rowRst_q;
  logic rowRst_d;
  logic [ROW_W-1:0] rowRstAddr_q;
  logic [ROW_W-1:0] rowRstAddr_d;
  logic [1:0] colour_q;
  logic [1:0] colour_d;

  always_comb begin
    xbar_d = xbar_q;
    if (!xbarAuto) begin
      xbar_d = ctrl_q[F_XB_MAN];
    end else if (xbarRise && stable_q[5]) begin
      xbar_d = ctrl_q[F_XB_INIT];
    end else if (xbarRise) begin
      // Alternate rows carry green on alternate lanes
      xbar_d = ~xbar_q;
    end
    sig_d = sigHoldRise ? pixelLevel : sig_q;
    cds_d = cds_q;
    cdsValid_d = 1'b0;
    if (rstHoldRise) begin
      // Video falls with light, so reset minus signal grows with light
      cds_d = (pixelLevel > sig_q) ? pixelLevel - sig_q : '0;
      cdsValid_d = 1'b1;
    end
    rowRst_d = sigHoldRise;
    rowRstAddr_d = sigHoldRise ? readPtr : rowRstAddr_q;
    colour_d = colourAt(readPtr[0], colPtr[0]);
  end

  always_ff @(posedge clk) begin
    if (sysRst) begin
      xbar_q <= 1'b0;
      sig_q <= '0;
      cds_q <= '0;
      cdsValid_q <= 1'b0;
      rowRst_q <= 1'b0;
      rowRstAddr_q <= '0;
      colour_q <= CLR_GREEN;
    end else if (clkEn) begin
      xbar_q <= xbar_d;
      sig_q <= sig_d;
      cds_q <= cds_d;
      cdsValid_q <= cdsValid_d;
      rowRst_q <= rowRst_d;
      rowRstAddr_q <= rowRstAddr_d;
      colour_q <= colour_d;
    end
  end

  assign xbarSwap = xbar_q;
  assign correctedLevel = cds_q;
  assign correctedValid = cdsValid_q;
  assign rowResetStrobe = rowRst_q;
  assign rowResetAddr = rowRstAddr_q;
  assign pixelColour = colour_q;
  assign ampEnable = ctrl_q[F_AMP +: 4];

  // Wishbone: ack one cycle after the request; writes land at the ack edge
  logic req;
  assign req = wbCyc && wbStb;

  always_comb begin
    ack_d = req && !ack_q;
    datR_d = datR_q;
    ctrl_d = ctrl_q;
    if (req && !ack_q) begin
      case (wbAdr)
        OFF_CTRL: datR_d = {16'h0000, ctrl_q};
        OFF_STATUS: datR_d = {29'h00000000, colour_q, xbar_q};
        OFF_ROWS: datR_d = {{(16-ROW_W){1'b0}}, resetPtr, {(16-ROW_W){1'b0}}, readPtr};
        OFF_COL: datR_d = {{(32-COL_W){1'b0}}, colPtr};
        OFF_CDS: datR_d = {{(32-PIX_W){1'b0}}, cds_q};
        default: datR_d = 32'h00000000;
      endcase
    end
    if (req && ack_q && wbWe && wbAdr == OFF_CTRL) begin
      if (wbSel[0]) begin
        ctrl_d[7:0] = wbDatW[7:0] & CTRL_MASK[7:0];
      end
      if (wbSel[1]) begin
        ctrl_d[15:8] = wbDatW[15:8] & CTRL_MASK[15:8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sysRst) begin
      ctrl_q <= CTRL_RESET;
      datR_q <= 32'h00000000;
      ack_q <= 1'b0;
    end else if (clkEn) begin
      ctrl_q <= ctrl_d;
      datR_q <= datR_d;
      ack_q <= ack_d;
    end
  end

  assign wbDatR = datR_q;
  assign wbAck = ack_q;

  // Checks
  sequence s_read_restart;
    clkEn && readRise && stable_q[1];
  endsequence

  sequence s_xbar_step;
    clkEn && xbarAuto && xbarRise && !stable_q[5];
  endsequence

  sequence s_row_read;
    clkEn && sigHoldRise;
  endsequence

  a_read_restart: assert property (@(posedge clk) disable iff (sysRst)
    s_read_restart |=> readPtr == '0) else $error("readout pointer not returned to first row");

  a_reset_restart: assert property (@(posedge clk) disable iff (sysRst)
    clkEn && resetRise && stable_q[3] |=> resetPtr == '0) else $error("reset pointer not returned to first row");

  a_read_advance: assert property (@(posedge clk) disable iff (sysRst)
    clkEn && readRise && !stable_q[1] && ySub == YS_FULL && readPtr < LAST_ROW
    |=> readPtr == $past(readPtr) + ROW_W'(1)) else $error("readout pointer did not step one row");

  a_ptr_independent: assert property (@(posedge clk) disable iff (sysRst)
    clkEn && readRise && !resetRise |=> $stable(resetPtr)) else $error("reset pointer moved with readout clock");

  a_ptr_range: assert property (@(posedge clk) disable iff (sysRst)
    readPtr <= LAST_ROW && resetPtr <= LAST_ROW && colPtr <= LAST_COL) else $error("pointer outside array");

  a_xbar_toggle: assert property (@(posedge clk) disable iff (sysRst)
    s_xbar_step |=> xbar_q != $past(xbar_q)) else $error("crossbar did not toggle");

  a_xbar_sync: assert property (@(posedge clk) disable iff (sysRst)
    clkEn && xbarAuto && xbarRise && stable_q[5] |=> xbar_q == $past(ctrl_q[F_XB_INIT]))
    else $error("crossbar sync did not load initial state");

  a_xbar_manual: assert property (@(posedge clk) disable iff (sysRst)
    !xbarAuto && clkEn ##1 !xbarAuto |-> xbar_q == $past(ctrl_q[F_XB_MAN])) else $error("manual crossbar mismatch");

  a_row_reset_after: assert property (@(posedge clk) disable iff (sysRst)
    s_row_read |=> rowResetStrobe && rowResetAddr == $past(readPtr)) else $error("row not reset after readout");

  a_cds_result: assert property (@(posedge clk) disable iff (sysRst)
    clkEn && rstHoldRise && pixelLevel > sig_q |=> correctedValid && correctedLevel == $past(pixelLevel - sig_q))
    else $error("double sampling result wrong");

  a_colour_origin: assert property (@(posedge clk) disable iff (sysRst)
    clkEn ##1 $past(readPtr) == '0 && $past(colPtr) == '0 |-> pixelColour == CLR_GREEN)
    else $error("origin pixel not green");

  a_amp_ctrl: assert property (@(posedge clk) disable iff (sysRst)
    clkEn && wbCyc && wbStb && wbAck && wbWe && wbAdr == OFF_CTRL && wbSel[1]
    |=> ampEnable == $past(wbDatW[F_AMP +: 4])) else $error("amplifier enables differ from written value");
endmodule

// ===== verification/row_pointer_and_output_crossbar_test.sv
`timescale 1ns/1ns
module row_pointer_and_output_crossbar_test
  import rpxb_pkg::*;
;
  logic clk = 1'b0, sysRst = 1'b1, clkEn = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0, wbDatR;
  logic wbAck, readoutRowClock, readoutRowSync, resetRowClock, resetRowSync, xbarRowClock, xbarSync;
  logic colClock, colSync, signalSampleHold, resetLevelSampleHold, rowResetStrobe, correctedValid, xbarSwap;
  logic [11:0] pixelLevel, correctedLevel, corrSeen = 12'h000;
  logic [ROW_W-1:0] readRowAddr, resetRowAddr, rowResetAddr, strobeAddr = '0;
  logic [COL_W-1:0] colAddr;
  logic [3:0] ampEnable;
  logic [1:0] pixelColour;
  int n_mismatch = 0, samples_checked = 0, strobes = 0;
  always #2 clk = ~clk;
  rpxb_top dut (.clk, .sysRst, .clkEn, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW, .wbDatR, .wbAck,
    .readoutRowClock, .readoutRowSync, .resetRowClock, .resetRowSync, .xbarRowClock, .xbarSync,
    .colClock, .colSync, .signalSampleHold, .resetLevelSampleHold, .pixelLevel, .readRowAddr,
    .resetRowAddr, .colAddr, .rowResetStrobe, .rowResetAddr, .correctedLevel, .correctedValid,
    .xbarSwap, .ampEnable, .pixelColour);
  rpxb_camera_ctl ctl (.clk, .readoutRowClock, .readoutRowSync, .resetRowClock, .resetRowSync,
    .xbarRowClock, .xbarSync, .colClock, .colSync, .signalSampleHold, .resetLevelSampleHold, .pixelLevel);
  // Pulses last one cycle, so they are caught here rather than polled
  always @(posedge clk) begin
    if (rowResetStrobe === 1'b1) begin
      strobes++;
      strobeAddr = rowResetAddr;
    end
    if (correctedValid === 1'b1) corrSeen = correctedLevel;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel,
      output logic [31:0] rd);
    int i;
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW, wbSel} <= {2'h3, we, adr, dat, sel};
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wbAck !== 1'b1 && i < 40);
    rd = wbDatR;
    {wbCyc, wbStb} <= 2'h0;
    if (wbAck !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    @(posedge clk);
  endtask
  // Rows go in pairs, then the mode's skip; the extra rows never skip
  function automatic logic [ROW_W-1:0] nextRow(input logic [ROW_W-1:0] r, input logic [2:0] m);
    logic [ROW_W-1:0] skip;
    skip = (m == 3'h3) ? 12'h004 : (m == 3'h5) ? 12'h00A : (m == 3'h1 || m > 3'h5) ? 12'h000 : 12'h002;
    if (r >= ACTIVE_ROWS) return (r == LAST_ROW) ? '0 : r + 12'h001;
    return r[0] ? r + 12'h001 + skip : r + 12'h001;
  endfunction
  function automatic logic [COL_W-1:0] nextCol(input logic [COL_W-1:0] c, input logic [2:0] m);
    logic [COL_W-1:0] skip;
    skip = (m == 3'h3) ? 13'h0014 : (m == 3'h4) ? 13'h0004 : (m == 3'h5) ? 13'h0008 : 13'h0000;
    if (c >= ACTIVE_COLS) skip = 13'h0000;
    return (c + 13'h0004 + skip > LAST_COL) ? '0 : c + 13'h0004 + skip;
  endfunction
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
  initial begin
    logic [31:0] rd;
    logic [ROW_W-1:0] er;
    logic [COL_W-1:0] ec;
    logic [11:0] sg, rs;
    int k, n, steps;
    void'($urandom(32'hC38D8FC7));
    repeat (4) @(posedge clk);
    sysRst <= 1'b0;
    wb(1'b0, OFF_CTRL, 32'h0, 4'hF, rd);
    chk(rd, 32'h0000F101);
    chk({28'h0, ampEnable}, 32'h0000000F);
    wb(1'b1, OFF_ROWS, 32'hFFFFFFFF, 4'hF, rd);
    wb(1'b0, OFF_ROWS, 32'h0, 4'hF, rd);
    chk(rd, 32'h0);
    wb(1'b0, 8'h40, 32'h0, 4'hF, rd);
    chk(rd, 32'h0);
    $display("test reset done");
    ctl.step(1'b1, 1'b1, 1'b1, 1'b0);
    k = $urandom_range(6, 1);
    n = $urandom_range(6, 1);
    repeat (k) ctl.step(1'b0, 1'b0, 1'b1, 1'b0);
    chk({20'h0, readRowAddr}, 32'h0);
    repeat (n) ctl.step(1'b0, 1'b1, 1'b1, 1'b0);
    wb(1'b0, OFF_ROWS, 32'h0, 4'hF, rd);
    chk(rd, {4'h0, 12'(n + k), 4'h0, 12'(n)});
    chk({20'h0, resetRowAddr}, 32'(n + k));
    chk({31'h0, xbarSwap}, 32'(n % 2));
    for (int i = 0; i < 5; i++) begin
      sg = 12'($urandom);
      rs = (i == 0) ? sg - 12'h001 : 12'($urandom);
      k = strobes;
      ctl.sampleRow(sg, rs);
      chk(32'(strobes - k), 32'h1);
      chk({20'h0, strobeAddr}, {20'h0, readRowAddr});
      chk({20'h0, corrSeen}, {20'h0, (rs > sg) ? rs - sg : 12'h000});
    end
    $display("test pointers done");
    for (int m = 0; m < 6; m++) begin
      wb(1'b1, OFF_CTRL, 32'h0000F001 | (32'(m) << 8), 4'h3, rd);
      ctl.step(1'b1, 1'b1, 1'b0, 1'b0);
      er = '0;
      steps = (m == 5) ? 530 : 8;
      for (int s = 1; s <= steps; s++) begin
        ctl.step(1'b0, 1'b1, 1'b0, 1'b0);
        er = nextRow(er, 3'(m));
        chk({20'h0, readRowAddr}, {20'h0, er});
        chk({31'h0, xbarSwap}, 32'(s % 2));
        chk({30'h0, pixelColour}, {30'h0, er[0] ? CLR_BLUE : CLR_GREEN});
      end
    end
    $display("test row modes done");
    for (int m = 0; m < 6; m++) begin
      wb(1'b1, OFF_CTRL, 32'h0000F101 | (32'(m) << 4), 4'h3, rd);
      ctl.step(1'b1, 1'b0, 1'b0, 1'b1);
      ec = '0;
      steps = (m == 5) ? 386 : 8;
      for (int s = 1; s <= steps; s++) begin
        ctl.step(1'b0, 1'b0, 1'b0, 1'b1);
        ec = nextCol(ec, 3'(m));
        chk({19'h0, colAddr}, {19'h0, ec});
      end
    end
    $display("test column modes done");
    wb(1'b1, OFF_CTRL, 32'h0000F103, 4'h3, rd);
    ctl.step(1'b1, 1'b1, 1'b0, 1'b0);
    chk({31'h0, xbarSwap}, 32'h1);
    ctl.step(1'b0, 1'b1, 1'b0, 1'b0);
    chk({31'h0, xbarSwap}, 32'h0);
    wb(1'b1, OFF_CTRL, 32'h0000F104, 4'h3, rd);
    // Two row clocks: a toggling crossbar would be back at 0, a manual one stays at 1
    repeat (2) ctl.step(1'b0, 1'b1, 1'b0, 1'b0);
    chk({31'h0, xbarSwap}, 32'h1);
    wb(1'b1, OFF_CTRL, 32'h0000F100, 4'h3, rd);
    repeat (2) @(posedge clk);
    chk({31'h0, xbarSwap}, 32'h0);
    $display("test crossbar done");
    // A whole row clock pulse while frozen must leave no trace
    clkEn <= 1'b0;
    ctl.step(1'b0, 1'b1, 1'b0, 1'b0);
    clkEn <= 1'b1;
    repeat (4) @(posedge clk);
    chk({20'h0, readRowAddr}, 32'h00000003);
    $display("test freeze done");
    k = $urandom_range(15, 0);
    wb(1'b1, OFF_CTRL, {16'hABCD, 4'(k), 12'h0FF}, 4'h2, rd);
    repeat (2) @(posedge clk);
    chk({28'h0, ampEnable}, 32'(k));
    wb(1'b0, OFF_CTRL, 32'h0, 4'hF, rd);
    chk(rd, {16'h0, 4'(k), 12'h000});
    $display("test amplifiers done");
    conclude();
  end
endmodule

// ===== verification/rpxb_camera_ctl.sv
`timescale 1ns/1ns
module rpxb_camera_ctl
  import rpxb_pkg::*;
#(
  parameter int PIX_W = 12
) (
  // Clock
  input wire logic clk,
  // Sensor timing pins
  output logic readoutRowClock,
  output logic readoutRowSync,
  output logic resetRowClock,
  output logic resetRowSync,
  output logic xbarRowClock,
  output logic xbarSync,
  output logic colClock,
  output logic colSync,
  output logic signalSampleHold,
  output logic resetLevelSampleHold,
  // Column level
  output logic [PIX_W-1:0] pixelLevel
);
  logic [9:0] pin = 10'h000;
  assign {resetLevelSampleHold, signalSampleHold, colSync, colClock, xbarSync, xbarRowClock} = pin[9:4];
  assign {resetRowSync, resetRowClock, readoutRowSync, readoutRowClock} = pin[3:0];
  initial pixelLevel = '0;
  // Four cycles per level, twice what the pin synchroniser needs
  task automatic drive(input logic [9:0] mask, input logic val);
    @(posedge clk);
    pin <= val ? (pin | mask) : (pin & ~mask);
    repeat (3) @(posedge clk);
  endtask
  // Crossbar rides on the readout clock and sync; reset pointer may lead alone or share the row
  task automatic step(input logic sync, input logic rd, input logic rs, input logic col);
    logic [9:0] clkMask;
    logic [9:0] syncMask;
    clkMask = {3'h0, col, 1'b0, rd, 1'b0, rs, 1'b0, rd};
    syncMask = sync ? (clkMask << 1) : 10'h000;
    if (sync) drive(syncMask, 1'b1);
    drive(clkMask, 1'b1);
    drive(clkMask, 1'b0);
    if (sync) drive(syncMask, 1'b0);
  endtask
  // Signal level held first, then the reset level
  task automatic sampleRow(input logic [PIX_W-1:0] sig, input logic [PIX_W-1:0] rst);
    // One edge first, so a back-to-back call never drives the level twice in one step
    @(posedge clk);
    pixelLevel <= sig;
    drive(10'h100, 1'b1);
    drive(10'h100, 1'b0);
    pixelLevel <= rst;
    drive(10'h200, 1'b1);
    drive(10'h200, 1'b0);
    pixelLevel <= ~rst;
  endtask
endmodule
